// >>> edc_consts.vh
// Constants for the extended-output page-mode memory host controller
`ifndef EDC_CONSTS_VH
`define EDC_CONSTS_VH
`define EDC_CLK_NS        10
`define EDC_WAKE_US       200
`define EDC_WAKE_CYC      ((`EDC_WAKE_US * 1000) / `EDC_CLK_NS)
`define EDC_WAKE_REFS     8
`define EDC_REF_MS        16
`define EDC_REF_ROWS      1024
`define EDC_REF_CYC       ((`EDC_REF_MS * 1000000 / `EDC_CLK_NS) / `EDC_REF_ROWS)
`define EDC_TRP_NS        40
`define EDC_TRP_CYC       ((`EDC_TRP_NS + `EDC_CLK_NS - 1) / `EDC_CLK_NS)
`define EDC_TRAS_NS       60
`define EDC_TRAS_CYC      ((`EDC_TRAS_NS + `EDC_CLK_NS - 1) / `EDC_CLK_NS)
`define EDC_TRCD_NS       20
`define EDC_TRCD_CYC      ((`EDC_TRCD_NS + `EDC_CLK_NS - 1) / `EDC_CLK_NS)
`define EDC_TCAS_NS       30
`define EDC_TCAS_CYC      ((`EDC_TCAS_NS + `EDC_CLK_NS - 1) / `EDC_CLK_NS)
`define EDC_TCP_NS        10
`define EDC_TCP_CYC       ((`EDC_TCP_NS + `EDC_CLK_NS - 1) / `EDC_CLK_NS)
`define EDC_TCSR_NS       10
`define EDC_TCSR_CYC      ((`EDC_TCSR_NS + `EDC_CLK_NS - 1) / `EDC_CLK_NS)
`define EDC_ROW_W         10
`define EDC_COL_W         10
`define EDC_DATA_W        16
`define EDC_FIFO_DEPTH    16
`define EDC_FIFO_AW       4
`define EDC_LANE_LO       7:0
`define EDC_LANE_HI       15:8
`endif

// >>> edc_fifo.v
// Write-data FIFO between the user port and the memory sequencer
`timescale 1ns/10ps
module edc_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   // Clock and reset
   input  wire             clock_i,
   input  wire             sys_rst_i,
   // Fill side
   input  wire             in_valid_i,
   output wire             in_ready_o,
   input  wire [WIDTH-1:0] in_data_i,
   // Drain side
   output wire             out_valid_o,
   input  wire             out_ready_i,
   output wire [WIDTH-1:0] out_data_o
);
   reg  [WIDTH-1:0] mem_r [0:DEPTH-1];
   reg  [AW-1:0]    wr_ptr_r;
   reg  [AW-1:0]    rd_ptr_r;
   reg  [AW:0]      count_r;
   wire             push;
   wire             pop;

   assign in_ready_o  = (count_r != DEPTH[AW:0]);
   assign out_valid_o = (count_r != {(AW+1){1'b0}});
   assign out_data_o  = mem_r[rd_ptr_r];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   always @(posedge clock_i) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data_i;
      end
   end

   always @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wr_ptr_r <= {AW{1'b0}};
         rd_ptr_r <= {AW{1'b0}};
         count_r  <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
         if (push & ~pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop & ~push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule // edc_fifo

// >>> edc_ctrl.v
// Host-side sequencer driving an asynchronous extended-output page-mode memory
`timescale 1ns/10ps
`include "edc_consts.vh"
module edc_ctrl #(
   parameter WAKE_CYC = `EDC_WAKE_CYC,
   parameter REF_CYC  = `EDC_REF_CYC
) (
   // Clock and reset
   input  wire                   clock_i,
   input  wire                   sys_rst_i,
   // User request
   input  wire                   req_valid_i,
   output wire                   req_ready_o,
   input  wire                   req_write_i,
   input  wire [1:0]             req_lanes_i,
   input  wire [`EDC_ROW_W-1:0]  req_row_i,
   input  wire [`EDC_COL_W-1:0]  req_col_i,
   // User write data
   input  wire                   wdata_valid_i,
   output wire                   wdata_ready_o,
   input  wire [`EDC_DATA_W-1:0] wdata_i,
   // User read data
   output reg                    rdata_valid_o,
   output reg  [`EDC_DATA_W-1:0] rdata_o,
   // Status
   output wire                   init_done_o,
   // Memory pins
   output reg                    row_strobe_n_o,
   output reg                    lower_byte_column_strobe_n_o,
   output reg                    upper_byte_column_strobe_n_o,
   output reg                    write_strobe_n_o,
   output reg                    output_gate_n_o,
   output reg  [9:0]             mem_addr_o,
   input  wire [`EDC_DATA_W-1:0] mem_dq_i,
   output reg  [`EDC_DATA_W-1:0] mem_dq_o,
   output reg                    mem_dq_oe_o
);
   // Sequencer states
   localparam [3:0] ST_WAKE   = 4'h0;
   localparam [3:0] ST_IDLE   = 4'h1;
   localparam [3:0] ST_RCD    = 4'h2;
   localparam [3:0] ST_CAS    = 4'h3;
   localparam [3:0] ST_CP     = 4'h4;
   localparam [3:0] ST_RASEND = 4'h5;
   localparam [3:0] ST_PRE    = 4'h6;
   localparam [3:0] ST_CSR    = 4'h7;
   localparam [3:0] ST_CBRRAS = 4'h8;
   localparam [3:0] ST_WDATA  = 4'h9;
   // Longest the row stays open for page hits, in clock cycles
   localparam [7:0] RAS_OPEN_MAX = 8'hc8;

   // Sequencer state, refresh bookkeeping and the current request
   reg  [3:0]             state_r;
   reg  [17:0]            wait_r;
   reg  [15:0]            ref_tmr_r;
   reg                    ref_due_r;
   reg                    ref_over_r;
   reg  [3:0]             wake_cnt_r;
   reg                    init_done_r;
   reg                    cur_write_r;
   reg  [1:0]             cur_lanes_r;
   reg  [`EDC_ROW_W-1:0]  cur_row_r;
   reg  [`EDC_COL_W-1:0]  cur_col_r;
   reg  [7:0]             ras_cnt_r;
   // FIFO drain and request decode
   wire                   fifo_valid;
   wire                   fifo_pop;
   wire [`EDC_DATA_W-1:0] fifo_data;
   wire                   page_hit;
   wire                   can_take;
   wire                   ref_start;

   edc_fifo #(
      .WIDTH (`EDC_DATA_W),
      .DEPTH (`EDC_FIFO_DEPTH),
      .AW    (`EDC_FIFO_AW)
   ) u_wfifo (
      .clock_i     (clock_i),
      .sys_rst_i   (sys_rst_i),
      .in_valid_i  (wdata_valid_i),
      .in_ready_o  (wdata_ready_o),
      .in_data_i   (wdata_i),
      .out_valid_o (fifo_valid),
      .out_ready_i (fifo_pop),
      .out_data_o  (fifo_data)
   );

   assign init_done_o = init_done_r;
   // A write waits for its data word in the FIFO
   assign can_take    = (~req_write_i | fifo_valid) & ~ref_due_r;
   assign req_ready_o = (state_r == ST_IDLE || state_r == ST_RASEND) && init_done_r &&
                        can_take && (state_r == ST_IDLE || page_hit);
   assign page_hit    = (req_row_i == cur_row_r) &&
                        (ras_cnt_r < RAS_OPEN_MAX);
   assign fifo_pop    = (state_r == ST_WDATA);
   // First cycle of a refresh row pulse serves the pending slot
   assign ref_start   = (state_r == ST_CBRRAS) && (wait_r == 18'h00000);

   // Refresh interval timer; a missed slot repeats the wake-up refreshes without the pause
   always @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ref_tmr_r  <= 16'h0000;
         ref_due_r  <= 1'b0;
         ref_over_r <= 1'b0;
      end else begin
         // Any wake-up in progress clears an overrun; none is flagged below until it ends
         if (~init_done_r) begin
            ref_over_r <= 1'b0;
         end
         if (ref_tmr_r == REF_CYC[15:0] - 16'h0001) begin
            ref_tmr_r <= 16'h0000;
            ref_due_r <= init_done_r;
            // A slot still pending at the next tick was missed
            if (ref_due_r && ~ref_start && init_done_r) begin
               ref_over_r <= 1'b1;
            end
         end else begin
            ref_tmr_r <= ref_tmr_r + 16'h0001;
            if (ref_start) begin
               ref_due_r <= 1'b0;
            end
         end
      end
   end

   // Wake-up: pause, then eight column-first refreshes chained through precharge.
   // Access: row fall, column address, optional write setup, column pulse,
   // column precharge, then the page state holds the row for same-row requests.
   // Refresh: column strobes fall before the row, so no external row is used.
   always @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_r                      <= ST_WAKE;
         wait_r                       <= 18'h00000;
         wake_cnt_r                   <= 4'h0;
         init_done_r                  <= 1'b0;
         cur_write_r                  <= 1'b0;
         cur_lanes_r                  <= 2'b00;
         cur_row_r                    <= {`EDC_ROW_W{1'b0}};
         cur_col_r                    <= {`EDC_COL_W{1'b0}};
         ras_cnt_r                    <= 8'h00;
         rdata_valid_o                <= 1'b0;
         rdata_o                      <= 16'h0000;
         row_strobe_n_o               <= 1'b1;
         lower_byte_column_strobe_n_o <= 1'b1;
         upper_byte_column_strobe_n_o <= 1'b1;
         write_strobe_n_o             <= 1'b1;
         output_gate_n_o              <= 1'b1;
         mem_addr_o                   <= 10'h000;
         mem_dq_o                     <= 16'h0000;
         mem_dq_oe_o                  <= 1'b0;
      end else begin
         rdata_valid_o <= 1'b0;
         if (~row_strobe_n_o && ras_cnt_r != 8'hff) begin
            ras_cnt_r <= ras_cnt_r + 8'h01;
         end
         case (state_r)
            ST_WAKE: begin
               // Power-up pause before the first refresh
               init_done_r <= 1'b0;
               if (wait_r == WAKE_CYC[17:0] - 18'h00001) begin
                  wait_r     <= 18'h00000;
                  wake_cnt_r <= 4'h0;
                  state_r    <= ST_CSR;
               end else begin
                  wait_r <= wait_r + 18'h00001;
               end
            end
            ST_IDLE: begin
               // A missed slot repeats the wake-up refreshes
               if (ref_over_r) begin
                  init_done_r <= 1'b0;
                  wake_cnt_r  <= 4'h0;
                  state_r     <= ST_CSR;
               end else if (ref_due_r) begin
                  state_r <= ST_CSR;
               end else if (req_ready_o && req_valid_i) begin
                  cur_write_r    <= req_write_i;
                  cur_lanes_r    <= req_lanes_i;
                  cur_row_r      <= req_row_i;
                  cur_col_r      <= req_col_i;
                  row_strobe_n_o <= 1'b0;
                  mem_addr_o     <= req_row_i;
                  ras_cnt_r      <= 8'h00;
                  wait_r         <= 18'h00000;
                  state_r        <= ST_RCD;
               end
            end
            ST_RCD: begin
               // Column address follows the row fall by one cycle
               mem_addr_o <= cur_col_r;
               if (wait_r >= `EDC_TRCD_CYC - 1) begin
                  wait_r  <= 18'h00000;
                  state_r <= cur_write_r ? ST_WDATA : ST_CAS;
               end else begin
                  wait_r <= wait_r + 18'h00001;
               end
            end
            ST_WDATA: begin
               // Early write: data and write strobe settle before column fall
               mem_dq_o         <= fifo_data;
               mem_dq_oe_o      <= 1'b1;
               write_strobe_n_o <= 1'b0;
               output_gate_n_o  <= 1'b1;
               state_r          <= ST_CAS;
            end
            ST_CAS: begin
               // Column pulse; read data is taken as the strobes rise
               lower_byte_column_strobe_n_o <= ~cur_lanes_r[0];
               upper_byte_column_strobe_n_o <= ~cur_lanes_r[1];
               output_gate_n_o              <= cur_write_r;
               if (wait_r >= `EDC_TCAS_CYC) begin
                  if (~cur_write_r) begin
                     rdata_o       <= mem_dq_i;
                     rdata_valid_o <= 1'b1;
                  end
                  lower_byte_column_strobe_n_o <= 1'b1;
                  upper_byte_column_strobe_n_o <= 1'b1;
                  write_strobe_n_o             <= 1'b1;
                  output_gate_n_o              <= 1'b1;
                  mem_dq_oe_o                  <= 1'b0;
                  wait_r                       <= 18'h00000;
                  state_r                      <= ST_CP;
               end else begin
                  wait_r <= wait_r + 18'h00001;
               end
            end
            ST_CP: begin
               // Column precharge before the next page access
               if (wait_r >= `EDC_TCP_CYC - 1) begin
                  wait_r  <= 18'h00000;
                  state_r <= ST_RASEND;
               end else begin
                  wait_r <= wait_r + 18'h00001;
               end
            end
            ST_RASEND: begin
               // Open row stays active for another column in the same row
               if (req_ready_o && req_valid_i) begin
                  cur_write_r <= req_write_i;
                  cur_lanes_r <= req_lanes_i;
                  cur_col_r   <= req_col_i;
                  mem_addr_o  <= req_col_i;
                  state_r     <= req_write_i ? ST_WDATA : ST_CAS;
               end else if (ras_cnt_r >= `EDC_TRAS_CYC) begin
                  row_strobe_n_o <= 1'b1;
                  wait_r         <= 18'h00000;
                  state_r        <= ST_PRE;
               end
            end
            ST_PRE: begin
               // Row precharge; wake-up refreshes chain back below
               if (wait_r >= `EDC_TRP_CYC - 1) begin
                  wait_r  <= 18'h00000;
                  state_r <= ST_IDLE;
               end else begin
                  wait_r <= wait_r + 18'h00001;
               end
            end
            ST_CSR: begin
               // Column strobes fall first so the internal counter picks the row
               lower_byte_column_strobe_n_o <= 1'b0;
               upper_byte_column_strobe_n_o <= 1'b0;
               // Refresh never hides behind an open row or a write
               write_strobe_n_o             <= 1'b1;
               output_gate_n_o              <= 1'b1;
               if (wait_r >= `EDC_TCSR_CYC) begin
                  row_strobe_n_o <= 1'b0;
                  wait_r         <= 18'h00000;
                  state_r        <= ST_CBRRAS;
               end else begin
                  wait_r <= wait_r + 18'h00001;
               end
            end
            ST_CBRRAS: begin
               // Row pulse of a refresh; counts the wake-up refreshes
               if (wait_r >= `EDC_TRAS_CYC - 1) begin
                  row_strobe_n_o               <= 1'b1;
                  lower_byte_column_strobe_n_o <= 1'b1;
                  upper_byte_column_strobe_n_o <= 1'b1;
                  wait_r                       <= 18'h00000;
                  state_r                      <= ST_PRE;
                  if (~init_done_r) begin
                     if (wake_cnt_r == `EDC_WAKE_REFS - 1) begin
                        init_done_r <= 1'b1;
                     end else begin
                        wake_cnt_r <= wake_cnt_r + 4'h1;
                        state_r    <= ST_PRE;
                     end
                  end
               end else begin
                  wait_r <= wait_r + 18'h00001;
               end
            end
            default: begin
               state_r <= ST_WAKE;
            end
         endcase
         // Wake-up refreshes chain back after precharge
         if (state_r == ST_PRE && wait_r >= `EDC_TRP_CYC - 1 && ~init_done_r &&
             wake_cnt_r != 4'h0) begin
            state_r <= ST_CSR;
         end
      end
   end
endmodule // edc_ctrl

// >>> edc_ctrl_props.sv
// Concurrent checks on the host pins of the page-mode memory sequencer
`timescale 1ns/10ps
module edc_ctrl_props #(
   parameter WAKE_CYC = 20000,
   parameter REF_CYC  = 1562
) (
   // Clock and reset
   input wire        clock_i,
   input wire        sys_rst_i,
   // User side
   input wire        req_ready_o,
   input wire        rdata_valid_o,
   input wire        init_done_o,
   // Memory pins
   input wire        row_strobe_n_o,
   input wire        lower_byte_column_strobe_n_o,
   input wire        upper_byte_column_strobe_n_o,
   input wire        write_strobe_n_o,
   input wire        output_gate_n_o,
   input wire [15:0] mem_dq_o,
   input wire        mem_dq_oe_o
);
   wire cs = !lower_byte_column_strobe_n_o || !upper_byte_column_strobe_n_o;
   reg  row_d_r;
   int  cyc_r;
   int  refs_r;
   int  gap_r;
   // Refresh seen as a row fall under a low column strobe
   wire rfsh = row_d_r && !row_strobe_n_o && cs;
   always @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         row_d_r <= 1'b1;
         cyc_r <= 0;
         refs_r <= 0;
         gap_r <= 0;
      end else begin
         row_d_r <= row_strobe_n_o;
         cyc_r <= cyc_r + 1;
         refs_r <= refs_r + rfsh;
         gap_r <= (rfsh || !init_done_o) ? 0 : gap_r + 1;
      end
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   AST_NO_REQ_IN_WAKE: assert property (!init_done_o |-> !req_ready_o)
      else $error("request taken before wake-up");
   AST_WAKE_PAUSE: assert property ($rose(init_done_o) |-> cyc_r >= WAKE_CYC)
      else $error("wake-up pause too short");
   AST_WAKE_REFS: assert property ($rose(init_done_o) |-> refs_r >= 8)
      else $error("fewer than eight wake-up refreshes");
   AST_REFRESH_GAP: assert property (gap_r < 3 * REF_CYC)
      else $error("refresh interval overrun");
   AST_EARLY_WRITE: assert property ($rose(cs) && !write_strobe_n_o
      |-> $past(!write_strobe_n_o) && mem_dq_oe_o)
      else $error("write strobe not ahead of column strobe");
   AST_WDATA_HOLD: assert property ($rose(cs) && !write_strobe_n_o
      |=> $stable(mem_dq_o) && mem_dq_oe_o)
      else $error("write data not held");
   AST_GATE_WHEN_DRIVE: assert property (mem_dq_oe_o |-> output_gate_n_o)
      else $error("host drives data with gate low");
   AST_READ_WE_HIGH: assert property (cs && !output_gate_n_o |-> write_strobe_n_o)
      else $error("write strobe low in a read");
   AST_ROW_PRECHARGE: assert property ($rose(row_strobe_n_o) |-> row_strobe_n_o[*4])
      else $error("row precharge too short");
   AST_RDATA_CAUSE: assert property (rdata_valid_o
      |-> $past(cs, 1) || $past(cs, 2) || $past(cs, 3))
      else $error("read word without column access");
endmodule // edc_ctrl_props

bind edc_ctrl edc_ctrl_props #(.WAKE_CYC(WAKE_CYC), .REF_CYC(REF_CYC)) u_props (
   .clock_i, .sys_rst_i, .req_ready_o, .rdata_valid_o, .init_done_o, .row_strobe_n_o,
   .lower_byte_column_strobe_n_o, .upper_byte_column_strobe_n_o, .write_strobe_n_o,
   .output_gate_n_o, .mem_dq_o, .mem_dq_oe_o);

// >>> edc_dram_model.sv
// Behavioural extended-output page-mode memory facing the host sequencer
`timescale 1ns/10ps
module edc_dram_model (
   // Strobes and address
   input  wire        row_n,
   input  wire        lcol_n,
   input  wire        ucol_n,
   input  wire        wr_n,
   input  wire        gate_n,
   input  wire [9:0]  addr,
   // Host data and resolved bus
   input  wire [15:0] host_d,
   input  wire        host_oe,
   output wire [15:0] dq
);
   logic [15:0] mem [int];
   reg   [9:0]  row;
   reg   [15:0] q;
   reg          ref_cyc = 1'b0;
   int          refs = 0;
   int          errs = 0;
   always @(negedge row_n) begin
      ref_cyc = !lcol_n || !ucol_n;
      if (ref_cyc)
         refs++;
      #1 row = addr;
   end
   always @(negedge lcol_n or negedge ucol_n) begin
      // Access completes a fixed delay after the column fall
      #1;
      if (!row_n && !ref_cyc) begin
         // Accesses before the wake-up refreshes are flagged
         if (refs < 8)
            errs++;
         if (!wr_n) begin
            if (!host_oe)
               errs++;
            if (!lcol_n)
               mem[{row, addr}][7:0] = host_d[7:0];
            if (!ucol_n)
               mem[{row, addr}][15:8] = host_d[15:8];
            q = mem[{row, addr}];
         end else begin
            q = mem[{row, addr}];
         end
      end
   end
   // The host issues early writes only; a write strobe under a low column strobe is flagged
   always @(negedge wr_n) begin
      if (!row_n && (!lcol_n || !ucol_n))
         errs++;
   end
   // Lanes float unless their column strobe and the gate are low in a read
   wire dl = !lcol_n && !gate_n && wr_n && !ref_cyc && !row_n;
   wire du = !ucol_n && !gate_n && wr_n && !ref_cyc && !row_n;
   wire [15:0] fl = host_oe ? host_d : ~host_d;
   assign dq = {du ? q[15:8] : fl[15:8], dl ? q[7:0] : fl[7:0]};
endmodule // edc_dram_model

// >>> edc_ctrl_bench.sv
// Self-checking bench for the page-mode memory sequencer
`timescale 1ns/10ps
module edc_ctrl_bench;
   logic        clock_i, sys_rst_i, req_valid_i, req_write_i, wdata_valid_i;
   logic [1:0]  req_lanes_i;
   logic [9:0]  req_row_i, req_col_i;
   logic [15:0] wdata_i;
   wire         req_ready_o, wdata_ready_o, rdata_valid_o, init_done_o, mem_dq_oe_o;
   wire         row_strobe_n_o, lower_byte_column_strobe_n_o, upper_byte_column_strobe_n_o;
   wire         write_strobe_n_o, output_gate_n_o;
   wire [9:0]   mem_addr_o;
   wire [15:0]  rdata_o, mem_dq_i, mem_dq_o;
   int          failures = 0;
   int          checks_done = 0;
   int          cycles = 0;
   int          base;

   edc_ctrl #(.WAKE_CYC(20), .REF_CYC(200)) DUT (
      .clock_i, .sys_rst_i, .req_valid_i, .req_ready_o, .req_write_i, .req_lanes_i,
      .req_row_i, .req_col_i, .wdata_valid_i, .wdata_ready_o, .wdata_i, .rdata_valid_o,
      .rdata_o, .init_done_o, .row_strobe_n_o, .lower_byte_column_strobe_n_o,
      .upper_byte_column_strobe_n_o, .write_strobe_n_o, .output_gate_n_o, .mem_addr_o,
      .mem_dq_i, .mem_dq_o, .mem_dq_oe_o);
   edc_dram_model u_mem (
      .row_n(row_strobe_n_o), .lcol_n(lower_byte_column_strobe_n_o),
      .ucol_n(upper_byte_column_strobe_n_o), .wr_n(write_strobe_n_o),
      .gate_n(output_gate_n_o), .addr(mem_addr_o), .host_d(mem_dq_o),
      .host_oe(mem_dq_oe_o), .dq(mem_dq_i));

   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end

   task test_done;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         test_done;
      end
   end

   task chk(input [15:0] got, input [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task push(input [15:0] d);
      wdata_i = d;
      wdata_valid_i = 1'b1;
      @(posedge clock_i);
      while (wdata_ready_o !== 1'b1) @(posedge clock_i);
      @(negedge clock_i);
      wdata_valid_i = 1'b0;
   endtask

   task issue(input w, input [1:0] ln, input [9:0] r, input [9:0] c);
      req_write_i = w;
      req_lanes_i = ln;
      req_row_i = r;
      req_col_i = c;
      req_valid_i = 1'b1;
      @(posedge clock_i);
      while (req_ready_o !== 1'b1) @(posedge clock_i);
      @(negedge clock_i);
      req_valid_i = 1'b0;
      if (!w)
         while (rdata_valid_o !== 1'b1) @(negedge clock_i);
   endtask

   task wr(input [1:0] ln, input [9:0] r, input [9:0] c, input [15:0] d);
      push(d);
      issue(1'b1, ln, r, c);
   endtask

   task rd(input [9:0] r, input [9:0] c, input [15:0] exp);
      issue(1'b0, 2'b11, r, c);
      chk(rdata_o, exp);
   endtask

   task t_wake;
      chk(init_done_o, 1'b0);
      chk(req_ready_o, 1'b0);
      while (init_done_o !== 1'b1) @(negedge clock_i);
      chk(u_mem.refs >= 8, 1'b1);
   endtask

   task t_write_read;
      wr(2'b11, 10'h005, 10'h011, 16'h1234);
      wr(2'b11, 10'h005, 10'h012, 16'ha5c3);
      rd(10'h005, 10'h011, 16'h1234);
      rd(10'h005, 10'h012, 16'ha5c3);
   endtask

   task t_lanes;
      wr(2'b01, 10'h005, 10'h011, 16'hffee);
      rd(10'h005, 10'h011, 16'h12ee);
      wr(2'b10, 10'h005, 10'h011, 16'h7700);
      rd(10'h005, 10'h011, 16'h77ee);
   endtask

   task t_fifo;
      for (int i = 0; i < 16; i++) push(16'h0f00 + i);
      chk(wdata_ready_o, 1'b0);
      for (int i = 0; i < 16; i++) issue(1'b1, 2'b11, 10'h020, i);
      chk(wdata_ready_o, 1'b1);
      rd(10'h020, 10'h000, 16'h0f00);
      rd(10'h020, 10'h00f, 16'h0f0f);
   endtask

   task t_refresh;
      base = u_mem.refs;
      repeat (650) @(negedge clock_i);
      chk(u_mem.refs - base >= 3, 1'b1);
      rd(10'h005, 10'h012, 16'ha5c3);
   endtask

   initial begin
      sys_rst_i = 1'b1;
      req_valid_i = 1'b0;
      req_write_i = 1'b0;
      req_lanes_i = 2'b00;
      req_row_i = 10'h000;
      req_col_i = 10'h000;
      wdata_valid_i = 1'b0;
      wdata_i = 16'h0000;
      repeat (12) @(posedge clock_i);
      @(negedge clock_i);
      sys_rst_i = 1'b0;
      t_wake;
      t_write_read;
      t_lanes;
      t_fifo;
      t_refresh;
      chk(u_mem.errs, 16'h0000);
      test_done;
   end
endmodule // edc_ctrl_bench
